/* File: hdl/prb_pkg.sv */
// constants, command codes and reset values of the rail limit command bank
// assumes a 20 MHz core clock and a two-page (two master channel) device
package prb_pkg;
  // command codes
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_VOLTAGE_FORMAT_REPORT = 8'h20;
  localparam logic [7:0] CMD_SET = 8'h21;
  localparam logic [7:0] CMD_CEIL = 8'h24;
  localparam logic [7:0] CMD_MHI = 8'h25;
  localparam logic [7:0] CMD_MLO = 8'h26;
  localparam logic [7:0] CMD_SCALE = 8'h29;
  localparam logic [7:0] CMD_VON = 8'h35;
  localparam logic [7:0] CMD_VOFF = 8'h36;
  localparam logic [7:0] CMD_CAL = 8'h38;
  localparam logic [7:0] CMD_OVF = 8'h40;
  localparam logic [7:0] CMD_OVW = 8'h42;
  localparam logic [7:0] CMD_UVW = 8'h43;
  localparam logic [7:0] CMD_UVF = 8'h44;
  localparam logic [7:0] CMD_OCF = 8'h46;
  localparam logic [7:0] CMD_OCW = 8'h4a;
  localparam logic [7:0] CMD_VOV = 8'h55;
  localparam logic [7:0] CMD_VUVW = 8'h58;
  localparam logic [7:0] CMD_DEV_CEIL = 8'ha5;
  localparam logic [7:0] CMD_COMP = 8'hd3;
  localparam logic [7:0] CMD_MODE = 8'hd4;
  localparam logic [7:0] CMD_LOAD = 8'hf7;
  // storage indices; indices from I_VON upward are shared by both pages
  localparam logic [4:0] I_SET = 5'h00, I_MHI = 5'h01, I_MLO = 5'h02, I_SCALE = 5'h03;
  localparam logic [4:0] I_CAL = 5'h04, I_OVF = 5'h05, I_OVW = 5'h06, I_UVW = 5'h07;
  localparam logic [4:0] I_UVF = 5'h08, I_OCF = 5'h09, I_OCW = 5'h0a, I_LOAD = 5'h0b;
  localparam logic [4:0] I_COMP = 5'h0c, I_MODE = 5'h0d, I_VON = 5'h0e, I_VOFF = 5'h0f;
  localparam logic [4:0] I_VOV = 5'h10, I_VUVW = 5'h11, I_NONE = 5'h12;
  localparam int NREG = 18;
  // reset values
  localparam logic [15:0] RST_SET = 16'h0666, RST_CEIL = 16'h119a, RST_MHI = 16'h06b8;
  localparam logic [15:0] RST_MLO = 16'h0614, RST_SCALE = 16'h0000, RST_VON = 16'hcb40;
  localparam logic [15:0] RST_VOFF = 16'hcb00, RST_CAL = 16'hca80, RST_OVF = 16'h070a;
  localparam logic [15:0] RST_OVW = 16'h3981, RST_UVW = 16'h0000, RST_UVF = 16'h05c3;
  localparam logic [15:0] RST_OCF = 16'hdbb8, RST_OCW = 16'hda80, RST_VOV = 16'hd3e0;
  localparam logic [15:0] RST_VUVW = 16'hcb26, RST_DEV_CEIL = 16'h3c00, RST_LOAD = 16'h0000;
  localparam logic [15:0] RST_COMP = 16'h00ae, RST_MODE = 16'h0002;
  localparam logic [7:0] VOLTAGE_FORMAT_REPORT_VAL = 8'h14;  // linear, exponent -12 (244 uV)
  localparam logic [7:0] COMMON_OK = 8'h60;  // bits 6:5 high when limits settled
  // field positions
  localparam int MODE_UVRESP_BIT = 0, MODE_MINON_BIT = 1;
  localparam int COMP_GM_LO = 5, COMP_R_HI = 4;
  // frame lengths in link clocks: direction bit, command, data bytes
  localparam logic [4:0] FRM_CMD = 5'd9, FRM_BYTE = 5'd17, FRM_WORD = 5'd25, FRM_RD = 5'd17;
  localparam logic [1:0] MSEL_NOM = 2'd0, MSEL_HI = 2'd1, MSEL_LO = 2'd2;
  // status bit positions
  localparam int GS_VOV = 0, GS_VUVW = 1, GS_CML = 2, GS_BUSY = 3;
  localparam int CS_OVF = 0, CS_UVF = 1, CS_OVW = 2, CS_UVW = 3, CS_LATCH = 4;
  // fault-limit settle time
  localparam int SETTLE_MS = 2;
  localparam int CLK_HZ = 20_000_000;
  localparam int SETTLE_CYC_DEF = SETTLE_MS * (CLK_HZ / 1000);

  function automatic logic [4:0] cmd_idx(input logic [7:0] c);
    case (c)
      CMD_SET: cmd_idx = I_SET;
      CMD_MHI: cmd_idx = I_MHI;
      CMD_MLO: cmd_idx = I_MLO;
      CMD_SCALE: cmd_idx = I_SCALE;
      CMD_CAL: cmd_idx = I_CAL;
      CMD_OVF: cmd_idx = I_OVF;
      CMD_OVW: cmd_idx = I_OVW;
      CMD_UVW: cmd_idx = I_UVW;
      CMD_UVF: cmd_idx = I_UVF;
      CMD_OCF: cmd_idx = I_OCF;
      CMD_OCW: cmd_idx = I_OCW;
      CMD_LOAD: cmd_idx = I_LOAD;
      CMD_COMP: cmd_idx = I_COMP;
      CMD_MODE: cmd_idx = I_MODE;
      CMD_VON: cmd_idx = I_VON;
      CMD_VOFF: cmd_idx = I_VOFF;
      CMD_VOV: cmd_idx = I_VOV;
      CMD_VUVW: cmd_idx = I_VUVW;
      default: cmd_idx = I_NONE;
    endcase
  endfunction

  function automatic logic [15:0] reg_rst(input int i);
    logic [15:0] t [NREG];
    t = '{RST_SET, RST_MHI, RST_MLO, RST_SCALE, RST_CAL, RST_OVF, RST_OVW, RST_UVW, RST_UVF,
          RST_OCF, RST_OCW, RST_LOAD, RST_COMP, RST_MODE, RST_VON, RST_VOFF, RST_VOV,
          RST_VUVW};
    reg_rst = t[i];
  endfunction
endpackage

/* File: hdl/prb_rail_bank.sv */
// command register bank of a two-channel step-down controller, reached over a
// clocked serial link; assumes ADC readings and channel states arrive on i_clk
// already in the same encoding as the limits they are compared with.
// Functional notes
// - pwm mode bit 1 set holds minimum on time at or above 30ns
// - pwm mode bit 0 set latches an operating rail off on stage undervoltage
// - compensation bits 7:5 pick amplifier gm from 1.00 to 5.73 mS
// - compensation bits 4:0 pick resistor, codes 0-4 give 1k, 31 gives 62k
// - conversion allowed from turn-on level, stops below turn-off level
// - input above input overvoltage limit raises input overvoltage fault
// - input undervoltage warning armed only after turn-on level and enable
// - format report is read only; writing it raises a communication fault
// - new set point waits for scale update and soft sequence to finish
// - ceiling word reads maximum for all output commands, follows scale gain
// - margin words give target under margin select, wait for scale update
// - feedback gain outside 1 to 9 raises communication fault, value kept
// - feedback or output above overvoltage fault limit raises a fault
// - feedback or output below undervoltage fault limit raises a fault while the channel is on
// - common status bits 6:5 held low while new fault limit settles
// - sense above overvoltage warning sets warning status and alert
// - sense below undervoltage warning sets warning status and alert while the channel is on
// - current-sense gain write unless both channels off is a communication fault
// - load emulator byte is paged, volatile and resets to zero
// - pwm mode write while channel on is discarded with a busy fault
`timescale 1ns/100ps
module prb_rail_bank
  import prb_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_CYC_DEF  // fault-limit settle time in i_clk cycles
) (
  input wire logic i_clk,  // core clock
  input wire logic i_rst_n,  // async reset, active low
  input wire logic i_lnk_clk,  // link clock, runs only inside frames
  input wire logic i_lnk_sel_n,  // frame select, active low
  input wire logic i_lnk_mosi,  // link data in, sampled on rising link clock
  output logic o_lnk_miso,  // link data out
  output logic o_lnk_miso_oe,  // link data out enable
  input wire logic [1:0] i_chan_on,  // channel operating
  input wire logic [1:0] i_chan_off_cmd,  // channel commanded off
  input wire logic i_unit_en,  // unit enabled
  input wire logic i_scale_busy,  // scale-loop update processing
  input wire logic [1:0] i_soft_seq,  // soft on/off sequence in progress
  input wire logic [1:0][1:0] i_margin_sel,  // per channel nominal, high or low
  input wire logic i_stage_uv,  // stage fault bus undervoltage pin
  input wire logic [15:0] i_vin_adc,  // measured input voltage
  input wire logic [1:0][15:0] i_vfb_adc,  // measured feedback voltage
  input wire logic [1:0][15:0] i_vout_adc,  // measured output voltage
  input wire logic [1:0][15:0] i_vsense_adc,  // measured sense differential
  input wire logic [13:0] i_alert_mask,  // 1 masks a status bit from alert
  input wire logic i_clear_faults,  // one-cycle pulse clears status
  output logic [1:0][15:0] o_target,  // regulation target
  output logic [1:0] o_min_on_lim,  // on time held at or above 30ns
  output logic [1:0][15:0] o_gm_us,  // amplifier gm in microsiemens
  output logic [1:0][15:0] o_rith_ohm,  // compensation resistor in ohms
  output logic [1:0][7:0] o_load_emu,  // load emulator byte
  output logic o_conv_allow,  // power conversion allowed
  output logic [3:0] o_gl_status,  // shared sticky status
  output logic [1:0][4:0] o_ch_status,  // per channel sticky status
  output logic [7:0] o_common_status,  // common status byte
  output logic o_alert_n  // alert, active low
);
  localparam int SW = $clog2(SETTLE_CYC + 1);

  function automatic logic [15:0] gm_of(input logic [2:0] c);
    case (c)
      3'd0: gm_of = 16'd1000;
      3'd1: gm_of = 16'd1680;
      3'd2: gm_of = 16'd2350;
      3'd3: gm_of = 16'd3020;
      3'd4: gm_of = 16'd3690;
      3'd5: gm_of = 16'd4360;
      3'd6: gm_of = 16'd5040;
      default: gm_of = 16'd5730;
    endcase
  endfunction

  // resistor table folded into its piecewise-linear segments
  function automatic logic [15:0] rith_of(input logic [4:0] c);
    logic [15:0] k;
    k = {11'h000, c};
    if (c <= 5'd4) rith_of = 16'd1000;
    else if (c <= 5'd8) rith_of = 16'(16'd1000 + 16'd250 * (k - 16'd4));
    else if (c <= 5'd16) rith_of = 16'(16'd2000 + 16'd500 * (k - 16'd8));
    else if (c <= 5'd19) rith_of = 16'(16'd6000 + 16'd1000 * (k - 16'd16));
    else if (c <= 5'd23) rith_of = 16'(16'd9000 + 16'd2000 * (k - 16'd19));
    else if (c <= 5'd27) rith_of = 16'(16'd20000 + 16'd4000 * (k - 16'd24));
    else rith_of = 16'(16'd38000 + 16'd8000 * (k - 16'd28));
  endfunction

  // gain word in 5s/11s linear form must lie in 1..9 inclusive
  function automatic logic l11_ok(input logic [15:0] w);
    logic [26:0] m;
    logic [4:0] n;
    m = {16'h0000, w[10:0]};
    n = 5'(-w[15:11]);
    if (w[10] || w[10:0] == 11'h000) l11_ok = 1'b0;
    else if (!w[15]) l11_ok = (m << w[15:11]) <= 27'd9;
    else l11_ok = (m >= (27'd1 << n)) && (m <= (27'd9 << n));
  endfunction

  // link side: bit counter lives only for the frame, capture stays afterwards
  wire lk_rst_n = i_rst_n & ~i_lnk_sel_n;
  logic [4:0] lk_cnt_r;
  logic [4:0] lk_len_r;
  logic [23:0] lk_data_r;
  logic lk_rnw_r;
  logic lk_tog_r;
  logic [15:0] rd_hold_r;

  always_ff @(posedge i_lnk_clk or negedge lk_rst_n) begin
    if (!lk_rst_n) lk_cnt_r <= 5'h00;
    else if (lk_cnt_r != 5'h1f) lk_cnt_r <= lk_cnt_r + 5'h01;
  end

  // toggle marks a new frame so a clockless select pulse commits nothing
  always_ff @(posedge i_lnk_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_len_r <= 5'h00;
      lk_data_r <= 24'h000000;
      lk_rnw_r <= 1'b0;
      lk_tog_r <= 1'b0;
    end else begin
      lk_data_r <= {lk_data_r[22:0], i_lnk_mosi};
      lk_len_r <= (lk_cnt_r == 5'h1f) ? lk_cnt_r : lk_cnt_r + 5'h01;
      if (lk_cnt_r == 5'h00) begin
        lk_rnw_r <= i_lnk_mosi;
        lk_tog_r <= ~lk_tog_r;
      end
    end
  end

  // read data comes from a word that is only rewritten between frames
  wire lk_rd_ph = lk_rnw_r & (lk_cnt_r != 5'h00) & (lk_cnt_r < FRM_RD);
  wire [3:0] lk_bit = 4'(5'd16 - lk_cnt_r);
  assign o_lnk_miso = lk_rd_ph & rd_hold_r[lk_bit];
  assign o_lnk_miso_oe = lk_rd_ph;

  // core side: frame end seen through a synchroniser on select and toggle
  logic [2:0] sel_q;
  logic [1:0] tog_q;
  logic tog_seen_r;
  logic [1:0] uv_q;
  wire frm_end = sel_q[1] & ~sel_q[2] & (tog_q[1] != tog_seen_r);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_q <= 3'h7;
      tog_q <= 2'h0;
      tog_seen_r <= 1'b0;
      uv_q <= 2'h0;
    end else begin
      sel_q <= {sel_q[1:0], i_lnk_sel_n};
      tog_q <= {tog_q[0], lk_tog_r};
      uv_q <= {uv_q[0], i_stage_uv};
      if (frm_end) tog_seen_r <= tog_q[1];
    end
  end

  // decode of the finished frame; link capture is quiet while this is read
  logic [15:0] regs_r [2][NREG];
  logic page_r;
  logic [1:0][15:0] ceil_w;
  wire is_byte = lk_len_r == FRM_BYTE;
  wire is_word = lk_len_r == FRM_WORD;
  wire [7:0] f_cmd = is_word ? lk_data_r[23:16] : is_byte ? lk_data_r[15:8] : lk_data_r[7:0];
  wire [15:0] f_val = is_byte ? {8'h00, lk_data_r[7:0]} : {lk_data_r[7:0], lk_data_r[15:8]};
  wire [4:0] f_idx = cmd_idx(f_cmd);
  wire f_byte_cmd = (f_idx == I_LOAD) | (f_idx == I_COMP) | (f_idx == I_MODE);
  wire f_pg = (f_idx >= I_VON) ? 1'b0 : page_r;
  wire f_len_ok = f_byte_cmd ? is_byte : is_word;
  wire f_vout = (f_idx <= I_MLO) | ((f_idx >= I_OVF) & (f_idx <= I_UVF));
  wire pg_wr = f_cmd == CMD_PAGE;
  wire wr_data = frm_end & ~lk_rnw_r & (is_byte | is_word);
  wire cml_pg = pg_wr & (~is_byte | (f_val > 16'h0001));
  // unknown and read-only codes, including the format report, map to I_NONE
  wire cml_reg = ~pg_wr & ((f_idx == I_NONE) | ~f_len_ok
    | ((f_idx == I_SCALE) & ~l11_ok(f_val))
    | ((f_idx == I_CAL) & ~&i_chan_off_cmd)
    | (f_vout & (f_val > ceil_w[page_r])));
  wire busy_w = ~cml_reg & (f_idx == I_MODE) & i_chan_on[page_r];
  wire wr_go = wr_data & ~pg_wr & ~cml_reg & ~busy_w;
  wire wr_cml = wr_data & (pg_wr ? cml_pg : cml_reg);
  wire wr_busy = wr_data & ~pg_wr & busy_w;
  wire lim_wr = wr_go & ((f_idx == I_OVF) | (f_idx == I_UVF));
  wire [15:0] rd_val = (f_cmd == CMD_VOLTAGE_FORMAT_REPORT) ? {8'h00, VOLTAGE_FORMAT_REPORT_VAL}
    : (f_cmd == CMD_CEIL) ? ceil_w[page_r]
    : (f_cmd == CMD_DEV_CEIL) ? RST_DEV_CEIL
    : pg_wr ? {15'h0000, page_r}
    : (f_idx == I_NONE) ? 16'h0000 : regs_r[f_pg][f_idx];

  // register storage; shared input-voltage words live in the page 0 row
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      page_r <= 1'b0;
      rd_hold_r <= 16'h0000;
      for (int p = 0; p < 2; p++) begin
        for (int i = 0; i < NREG; i++) regs_r[p][i] <= reg_rst(i);
      end
    end else begin
      if (wr_data & pg_wr & ~cml_pg) page_r <= f_val[0];
      if (wr_go) regs_r[f_pg][f_idx] <= f_val;
      if (frm_end & ~lk_rnw_r & (lk_len_r == FRM_CMD)) rd_hold_r <= rd_val;
    end
  end

  // fault-limit settle timer; detection and status bits 6:5 wait for it
  logic [SW-1:0] settle_r;
  logic [7:0] common_r;
  wire settling = settle_r != '0;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settle_r <= '0;
      common_r <= COMMON_OK;
    end else begin
      if (lim_wr) settle_r <= SW'(SETTLE_CYC);
      else if (settling) settle_r <= settle_r - SW'(1);
      common_r <= (settling | lim_wr) ? 8'h00 : COMMON_OK;
    end
  end

  // input voltage supervision and shared status, set wins over clear
  logic conv_r;
  logic armed_r;
  logic [3:0] gs_r;
  wire [3:0] gs_set;
  assign gs_set[GS_VOV] = i_vin_adc > regs_r[0][I_VOV];
  assign gs_set[GS_VUVW] = armed_r & (i_vin_adc < regs_r[0][I_VUVW]);
  assign gs_set[GS_CML] = wr_cml;
  assign gs_set[GS_BUSY] = wr_busy;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      conv_r <= 1'b0;
      armed_r <= 1'b0;
      gs_r <= 4'h0;
    end else begin
      if (i_vin_adc >= regs_r[0][I_VON]) conv_r <= 1'b1;
      else if (i_vin_adc < regs_r[0][I_VOFF]) conv_r <= 1'b0;
      if (!conv_r) armed_r <= 1'b0;
      else if ((i_vin_adc > regs_r[0][I_VON]) & i_unit_en) armed_r <= 1'b1;
      gs_r <= (gs_r & ~{4{i_clear_faults}}) | gs_set;
    end
  end

  // per channel: applied targets, compensation outputs and rail supervision
  logic [1:0][4:0] cs_w;
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [4:0] st_r;
    logic [15:0] set_r;
    logic [15:0] mhi_r;
    logic [15:0] mlo_r;
    logic [15:0] tgt_r;
    logic [15:0] gm_r;
    logic [15:0] rith_r;
    wire scl_def = regs_r[c][I_SCALE] != 16'h0000;
    wire [15:0] fbk = scl_def ? i_vout_adc[c] : i_vfb_adc[c];
    wire [7:0] comp = regs_r[c][I_COMP][7:0];
    wire [4:0] cs_set;
    assign ceil_w[c] = scl_def ? RST_DEV_CEIL : RST_CEIL;
    assign cs_set[CS_OVF] = ~settling & (fbk > regs_r[c][I_OVF]);
    assign cs_set[CS_UVF] = ~settling & i_chan_on[c] & (fbk < regs_r[c][I_UVF]);
    assign cs_set[CS_OVW] = i_vsense_adc[c] > regs_r[c][I_OVW];
    assign cs_set[CS_UVW] = i_chan_on[c] & (i_vsense_adc[c] < regs_r[c][I_UVW]);
    // latch-off only while operating; a rail that is off ignores the bus
    assign cs_set[CS_LATCH] = regs_r[c][I_MODE][MODE_UVRESP_BIT] & uv_q[1] & i_chan_on[c];

    // written set point and margin values reach the loop only when no update is in flight; compensation follows every cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        set_r <= RST_SET;
        mhi_r <= RST_MHI;
        mlo_r <= RST_MLO;
        tgt_r <= RST_SET;
        gm_r <= 16'h0000;
        rith_r <= 16'h0000;
        st_r <= 5'h00;
      end else begin
        if (!i_scale_busy && !i_soft_seq[c]) set_r <= regs_r[c][I_SET];
        if (!i_scale_busy) begin
          mhi_r <= regs_r[c][I_MHI];
          mlo_r <= regs_r[c][I_MLO];
        end
        tgt_r <= (i_margin_sel[c] == MSEL_HI) ? mhi_r
          : (i_margin_sel[c] == MSEL_LO) ? mlo_r : set_r;
        gm_r <= gm_of(comp[7:COMP_GM_LO]);
        rith_r <= rith_of(comp[COMP_R_HI:0]);
        st_r <= (st_r & ~{5{i_clear_faults}}) | cs_set;
      end
    end
    assign cs_w[c] = st_r;
    assign o_target[c] = tgt_r;
    assign o_gm_us[c] = gm_r;
    assign o_rith_ohm[c] = rith_r;
    assign o_min_on_lim[c] = regs_r[c][I_MODE][MODE_MINON_BIT];
    assign o_load_emu[c] = regs_r[c][I_LOAD][7:0];
  end

  // alert follows any unmasked sticky bit, one cycle behind it
  logic alert_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) alert_r <= 1'b0;
    else alert_r <= |({cs_w[1], cs_w[0], gs_r} & ~i_alert_mask);
  end

  assign o_conv_allow = conv_r;
  assign o_gl_status = gs_r;
  assign o_ch_status = cs_w;
  assign o_common_status = common_r;
  assign o_alert_n = ~alert_r;
endmodule

/* File: test/prb_rail_bank_chk.sv */
// timing checks on the ports of the rail limit command bank
// assumes one core clock domain; link select is only sampled, not clocked
`timescale 1ns/100ps
module prb_rail_bank_chk
  import prb_pkg::*;
#(
  parameter int SETTLE_CYC = 20  // settle length handed on from the design
) (
  input wire logic i_clk,  // core clock
  input wire logic i_rst_n,  // async reset, active low
  input wire logic i_lnk_sel_n,  // frame select
  input wire logic [1:0] i_chan_on,  // channel operating
  input wire logic i_scale_busy,  // scale update busy
  input wire logic [1:0][1:0] i_margin_sel,  // margin select
  input wire logic [13:0] i_alert_mask,  // alert mask
  input wire logic i_clear_faults,  // status clear
  input wire logic [1:0][15:0] o_target,  // regulation target
  input wire logic [1:0] o_min_on_lim,  // on time limit
  input wire logic [1:0][15:0] o_gm_us,  // amplifier gm
  input wire logic [1:0][15:0] o_rith_ohm,  // resistor
  input wire logic [1:0][7:0] o_load_emu,  // load emulator
  input wire logic [3:0] o_gl_status,  // shared status
  input wire logic [1:0][4:0] o_ch_status,  // channel status
  input wire logic [7:0] o_common_status,  // common status
  input wire logic o_alert_n  // alert
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  int low_cnt_r;
  // length of the settle window, so a stuck window is caught
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      low_cnt_r <= 0;
    end else begin
      low_cnt_r <= (o_common_status == 8'h00) ? low_cnt_r + 1 : 0;
    end
  end
  AST_STICKY_GL: assert property (|($past(o_gl_status) & ~o_gl_status) |-> $past(i_clear_faults))
    else $error("shared status dropped without clear");
  AST_STICKY_CH: assert property (|($past(o_ch_status) & ~o_ch_status) |-> $past(i_clear_faults))
    else $error("channel status dropped without clear");
  AST_COMMON_VAL: assert property (o_common_status == 8'h60 || o_common_status == 8'h00)
    else $error("common status has a stray value");
  AST_COMMON_LEN: assert property (low_cnt_r <= SETTLE_CYC + 8)
    else $error("settle window too long");
  AST_FRAME_HOLD: assert property ((!i_lnk_sel_n)[*8] |-> $stable(o_gm_us) &&
    $stable(o_rith_ohm) && $stable(o_load_emu) && $stable(o_min_on_lim))
    else $error("register moved inside a frame");
  AST_TARGET_HOLD: assert property ((i_scale_busy && $stable(i_margin_sel))[*3]
    |-> $stable(o_target)) else $error("target moved while scale busy");
  AST_ALERT_MASK: assert property ($past(i_alert_mask) == 14'h3fff |-> o_alert_n)
    else $error("alert while fully masked");
  AST_ALERT_SET: assert property ($rose(o_gl_status[GS_CML]) && !i_alert_mask[GS_CML]
    |=> !o_alert_n) else $error("alert missing after fault");
  AST_CH_UV: assert property ($rose(o_ch_status[0][CS_UVF]) |-> $past(i_chan_on[0]))
    else $error("undervoltage flagged while off");
  cover property ($rose(o_gl_status[GS_CML]));
  cover property ($fell(o_common_status[5]));
  cover property ($changed(o_target[0]));
endmodule
bind prb_rail_bank prb_rail_bank_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_lnk_sel_n(i_lnk_sel_n), .i_chan_on(i_chan_on),
  .i_scale_busy(i_scale_busy), .i_margin_sel(i_margin_sel), .i_alert_mask(i_alert_mask),
  .i_clear_faults(i_clear_faults), .o_target(o_target), .o_min_on_lim(o_min_on_lim),
  .o_gm_us(o_gm_us), .o_rith_ohm(o_rith_ohm), .o_load_emu(o_load_emu),
  .o_gl_status(o_gl_status), .o_ch_status(o_ch_status),
  .o_common_status(o_common_status), .o_alert_n(o_alert_n));

/* File: test/prb_host_model.sv */
// host end of the serial register link: link clock, select and data line
// assumes callers never overlap frames
`timescale 1ns/100ps
module prb_host_model (
  output logic o_lnk_clk,  // link clock, low between frames
  output logic o_sel_n,  // frame select, active low
  output logic o_mosi,  // data to the bank
  input wire logic i_miso  // data from the bank
);
  initial begin
    o_lnk_clk = 1'b0;
    o_sel_n = 1'b1;
    o_mosi = 1'b0;
  end
  // data set while clock low, read back just before the fall
  task automatic bitx(input logic b, output logic s);
    o_mosi = b;
    #62.5 o_lnk_clk = 1'b1;
    #62.5 s = i_miso;
    o_lnk_clk = 1'b0;
  endtask
  // nb bits of f msb first; the first 16 bits read come back in q
  // margin order is the caller's choice so is the settle wait
  task automatic frame(input logic [24:0] f, input int nb, output logic [15:0] q);
    logic s;
    q = 16'h0000;
    #7 o_sel_n = 1'b0;
    for (int k = 0; k < nb; k++) begin
      bitx(f[24 - k], s);
      // the bank shows bit 15 right after the direction edge, so bits 0..15 are the word
      if (k < 16) q = {q[14:0], s};
    end
    #30 o_sel_n = 1'b1;
    o_mosi = ~o_mosi;  // released line must not keep the last bit
    #520;  // idle gap well above the minimum
  endtask
endmodule

/* File: test/tb_prb_rail_bank.sv */
// self-checking bench for the rail limit command bank
// assumes the host model for all link traffic
`timescale 1ns/100ps
module tb_prb_rail_bank;
  import prb_pkg::*;
  localparam int SC = 20;
  logic i_clk, i_rst_n, lclk, sel_n, mosi, miso, busy, suv, clr, conv, alert_n;
  logic [1:0] chan_on, off_cmd, min_on;
  logic [15:0] vin, q;
  logic [1:0][15:0] vfb, target, gm, rith;
  logic [13:0] mask;
  logic [1:0][7:0] load;
  logic [1:0][4:0] chs;
  logic [3:0] gls;
  logic [7:0] common;
  int err_count, n_checks;
  logic [7:0] rc [9] = '{8'h21, 8'h24, 8'h25, 8'h26, 8'h35, 8'h55, 8'ha5, 8'hf7, 8'h20};
  logic [15:0] rv [9] = '{16'h0666, 16'h119a, 16'h06b8, 16'h0614, 16'hcb40, 16'hd3e0,
    16'h3c00, 16'h0000, 16'h0014};
  logic [4:0] rct [8] = '{5'h00, 5'h04, 5'h05, 5'h09, 5'h10, 5'h14, 5'h18, 5'h1f};
  int gmt [8] = '{1000, 1680, 2350, 3020, 3690, 4360, 5040, 5730};
  int rot [8] = '{1000, 1000, 1250, 2500, 6000, 11000, 20000, 62000};
  prb_rail_bank #(.SETTLE_CYC(SC)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_lnk_clk(lclk),
    .i_lnk_sel_n(sel_n), .i_lnk_mosi(mosi), .o_lnk_miso(miso), .o_lnk_miso_oe(),
    .i_chan_on(chan_on), .i_chan_off_cmd(off_cmd), .i_unit_en(1'b1), .i_scale_busy(busy),
    .i_soft_seq(2'b00), .i_margin_sel('0), .i_stage_uv(suv), .i_vin_adc(vin),
    .i_vfb_adc(vfb), .i_vout_adc('0), .i_vsense_adc('0), .i_alert_mask(mask),
    .i_clear_faults(clr), .o_target(target), .o_min_on_lim(min_on), .o_gm_us(gm),
    .o_rith_ohm(rith), .o_load_emu(load), .o_conv_allow(conv), .o_gl_status(gls),
    .o_ch_status(chs), .o_common_status(common), .o_alert_n(alert_n));
  prb_host_model host (.o_lnk_clk(lclk), .o_sel_n(sel_n), .o_mosi(mosi), .i_miso(miso));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  task automatic nclk(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic w(input logic [7:0] c, input logic [15:0] d, input int n);
    host.frame({1'b0, c, d[7:0], d[15:8]}, n, q);
    nclk(1);
  endtask
  task automatic rd(input logic [7:0] c);
    host.frame({1'b0, c, 16'h0000}, 9, q);
    host.frame({1'b1, 24'h000000}, 17, q);
    nclk(1);
  endtask
  task automatic clear;
    nclk(1);
    clr = 1'b1;
    nclk(1);
    clr = 1'b0;
  endtask
  task automatic finish_test;
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // a hung run is cut short and counted
  initial begin
    #1_000_000;
    err_count++;
    finish_test;
  end
  initial begin
    {i_rst_n, chan_on, busy, suv, clr, vin, vfb} = '0;
    off_cmd = 2'b11;
    mask = 14'h3fff;
    nclk(3);
    i_rst_n = 1'b1;
    nclk(6);
    for (int i = 0; i < 9; i++) begin
      rd(rc[i]);
      chk(q, rv[i]);
    end
    w(8'h20, 16'h0015, 17);
    chk(16'(gls[GS_CML]), 16'h0001);
    chk(16'(alert_n), 16'h0001);
    clear;
    mask = '0;
    vfb[0] = 16'h0800;
    nclk(3);
    chk(16'(chs[0][CS_OVF]), 16'h0001);
    chk(16'(alert_n), 16'h0000);
    vfb[0] = 16'h0600;
    clear;
    w(8'h29, 16'h000a, 25);
    rd(8'h29);
    chk(q, 16'h0000);
    chk(16'(gls[GS_CML]), 16'h0001);
    clear;
    w(8'h29, 16'h0001, 25);
    rd(8'h24);
    chk(q, 16'h3c00);
    off_cmd = 2'b10;
    w(8'h38, 16'hca00, 25);
    chk(16'(gls[GS_CML]), 16'h0001);
    off_cmd = 2'b11;
    clear;
    w(8'h38, 16'hca00, 25);
    rd(8'h38);
    chk(q, 16'hca00);
    chk(16'(gls[GS_CML]), 16'h0000);
    // mode byte refused while the channel runs
    {chan_on, off_cmd} = 4'b0110;
    w(8'hd4, 16'h0001, 17);
    chk(16'(gls[GS_BUSY]), 16'h0001);
    chk(16'(min_on[0]), 16'h0001);
    {chan_on, off_cmd} = 4'b0011;
    w(8'hd4, 16'h0001, 17);
    chk(16'(min_on[0]), 16'h0000);
    chan_on = 2'b01;
    suv = 1'b1;
    nclk(6);
    chk(16'(chs[0][CS_LATCH]), 16'h0001);
    chk(16'(chs[1][CS_LATCH]), 16'h0000);
    {chan_on, suv} = 3'b000;
    clear;
    for (int i = 0; i < 8; i++) begin
      w(8'hd3, {8'h00, 3'(i), rct[i]}, 17);
      chk(gm[0], 16'(gmt[i]));
      chk(rith[0], 16'(rot[i]));
    end
    w(8'h00, 16'h0001, 17);
    w(8'hf7, 16'h0003, 17);
    chk(16'(load[1]), 16'h0003);
    chk(16'(load[0]), 16'h0000);
    w(8'h00, 16'h0000, 17);
    busy = 1'b1;
    w(8'h21, 16'h0700, 25);
    nclk(4);
    chk(target[0], 16'h0666);
    busy = 1'b0;
    nclk(4);
    chk(target[0], 16'h0700);
    // new limit while running: settle flags low, then back
    chan_on = 2'b01;
    w(8'h40, 16'h0700, 25);
    chk(16'(common), 16'h0000);
    nclk(SC);
    chk(16'(common), 16'h0060);
    chk(16'(chs[0][CS_UVF]), 16'h0001);
    chan_on = 2'b00;
    vin = 16'hcb50;
    nclk(4);
    chk(16'(conv), 16'h0001);
    vin = 16'hd400;
    nclk(4);
    chk(16'(gls[GS_VOV]), 16'h0001);
    vin = 16'hca00;
    nclk(4);
    chk(16'(conv), 16'h0000);
    chk(16'(gls[GS_VUVW]), 16'h0001);
    // a cut-short word frame must not land
    host.frame({1'b0, 8'h21, 16'h3412}, 20, q);
    rd(8'h21);
    chk(q, 16'h0700);
    finish_test;
  end
endmodule
